// *** sqdr_pkg.sv ***
// Package: register map, field layout and reset values for quad results
package sqdr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] SQDR_OFS_QUAD0 = 12'h238; // First quad word
  localparam logic [11:0] SQDR_OFS_QUAD2 = 12'h240; // Quad 2 result
  localparam logic [11:0] SQDR_OFS_QUAD3 = 12'h244; // Quad 3 result

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int SQDR_EXP_LSB = 0;  // Expected byte
  localparam int SQDR_ACT_LSB = 8;  // Actual byte
  localparam int SQDR_CNT_LSB = 16; // Error counter
  localparam int SQDR_SEL_LSB = 24; // Lane select
  localparam int SQDR_SRC_BIT = 30; // Counter source flag

  // ----------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [7:0] SQDR_BYTE_RST = 8'h00; // Data bytes reset
  localparam logic [1:0] SQDR_SEL_RST  = 2'h0;  // Lane select reset
  localparam logic [7:0] SQDR_CNT_MAX  = 8'hFF; // Saturation point
  localparam int         SQDR_LANES    = 4;     // Lanes per quad

  // Checker mode of one lane slot
  typedef enum logic [1:0] {
    SQDR_MODE_OFF  = 2'b00,
    SQDR_MODE_USER = 2'b01,
    SQDR_MODE_PRBS = 2'b10
  } sqdr_mode_t;

endpackage

// *** sqdr_lane.sv ***
// File: per-lane capture of mismatch bytes and saturating error count
`timescale 1ns/1ps
module sqdr_lane
  import sqdr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Checker enables for the lane's quad
  input  wire logic       user_pattern_check,
  input  wire logic       prbs_en,
  // Checker events
  input  wire logic       err_pulse,
  input  wire logic [7:0] exp_data,
  input  wire logic [7:0] act_data,
  // Results
  output logic      [7:0] exp_q,
  output logic      [7:0] act_q,
  output logic      [7:0] cnt_q
);

  logic [7:0] exp_d; // Next expected byte
  logic [7:0] act_d; // Next actual byte
  logic [7:0] cnt_d; // Next count

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Counter clears when no checker runs; saturates rather than wraps
  always_comb begin
    exp_d = exp_q;
    act_d = act_q;
    cnt_d = cnt_q;
    if (!user_pattern_check && !prbs_en) begin
      cnt_d = SQDR_BYTE_RST;
    end else if (err_pulse && cnt_q != SQDR_CNT_MAX) begin
      cnt_d = cnt_q + 8'h01;
    end
    // Bytes are only meaningful for user pattern mismatches
    if (user_pattern_check && err_pulse) begin
      exp_d = exp_data;
      act_d = act_data;
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      exp_q <= SQDR_BYTE_RST;
      act_q <= SQDR_BYTE_RST;
      cnt_q <= SQDR_BYTE_RST;
    end else begin
      exp_q <= exp_d;
      act_q <= act_d;
      cnt_q <= cnt_d;
    end
  end

  // Count never moves past its limit
  a_cnt_saturates:
    assert property (@(posedge sys_clk) disable iff (!rstn)
    (cnt_q == SQDR_CNT_MAX && (user_pattern_check || prbs_en))
      |=> cnt_q == SQDR_CNT_MAX)
    else $error("counter wrapped past saturation");

  a_cnt_clears:
    assert property (@(posedge sys_clk) disable iff (!rstn)
    (!user_pattern_check && !prbs_en) |=> cnt_q == 8'h00)
    else $error("counter not cleared while checkers off");

endmodule

// *** sqdr_top.sv ***
// File: quad 2 and quad 3 lane diagnostic result registers
`timescale 1ns/1ps
module sqdr_top
  import sqdr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Register access port (configuration, management or virtual interface)
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata_q,
  output logic             reg_ack_q,
  // Serial EEPROM / I2C preload of the lane select fields
  input  wire logic        eeprom_load,
  input  wire logic [11:0] eeprom_addr,
  input  wire logic [31:0] eeprom_data,
  // Checker enables from the physical layer test register
  input  wire logic        q2_user_en,
  input  wire logic        q2_prbs_en,
  input  wire logic        q3_user_en,
  input  wire logic        q3_prbs_en,
  // Per-lane checker events, lane index = quad lane 0..3
  input  wire logic [3:0]  q2_err,
  input  wire logic [31:0] q2_exp,
  input  wire logic [31:0] q2_act,
  input  wire logic [3:0]  q3_err,
  input  wire logic [31:0] q3_exp,
  input  wire logic [31:0] q3_act,
  // Lane select fields, for observation
  output logic      [1:0]  q2_sel_q,
  output logic      [1:0]  q3_sel_q
);

  logic [1:0]  q2_sel_d;    // Next quad 2 select
  logic [1:0]  q3_sel_d;    // Next quad 3 select
  logic [31:0] rdata_d;     // Next read data
  logic        ack_d;       // Next acknowledge
  logic [7:0]  q2_exp_r [SQDR_LANES]; // Quad 2 lane expected bytes
  logic [7:0]  q2_act_r [SQDR_LANES]; // Quad 2 lane actual bytes
  logic [7:0]  q2_cnt_r [SQDR_LANES]; // Quad 2 lane counters
  logic [7:0]  q3_exp_r [SQDR_LANES]; // Quad 3 lane expected bytes
  logic [7:0]  q3_act_r [SQDR_LANES]; // Quad 3 lane actual bytes
  logic [7:0]  q3_cnt_r [SQDR_LANES]; // Quad 3 lane counters

  // ----------------------------------------------------------------------
  // Lane slots; slot n is station lane base+n of the quad
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < SQDR_LANES; i++) begin : g_lane
    sqdr_lane u_q2 (
      .sys_clk            (sys_clk),
      .rstn               (rstn),
      .user_pattern_check (q2_user_en),
      .prbs_en            (q2_prbs_en),
      .err_pulse          (q2_err[i]),
      .exp_data           (q2_exp[8*i +: 8]),
      .act_data           (q2_act[8*i +: 8]),
      .exp_q              (q2_exp_r[i]),
      .act_q              (q2_act_r[i]),
      .cnt_q              (q2_cnt_r[i])
    );
    sqdr_lane u_q3 (
      .sys_clk            (sys_clk),
      .rstn               (rstn),
      .user_pattern_check (q3_user_en),
      .prbs_en            (q3_prbs_en),
      .err_pulse          (q3_err[i]),
      .exp_data           (q3_exp[8*i +: 8]),
      .act_data           (q3_act[8*i +: 8]),
      .exp_q              (q3_exp_r[i]),
      .act_q              (q3_act_r[i]),
      .cnt_q              (q3_cnt_r[i])
    );
  end

  // ----------------------------------------------------------------------
  // Read word assembly
  // ----------------------------------------------------------------------
  // Source flag is 1 only when PRBS runs without the user pattern checker
  function automatic logic [31:0] pack_word(
    input logic [7:0] e,
    input logic [7:0] a,
    input logic [7:0] c,
    input logic [1:0] s,
    input logic       prbs_src
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[SQDR_EXP_LSB +: 8] = e;
    w[SQDR_ACT_LSB +: 8] = a;
    w[SQDR_CNT_LSB +: 8] = c;
    w[SQDR_SEL_LSB +: 2] = s;
    w[SQDR_SRC_BIT]      = prbs_src;
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Select fields and access port
  // ----------------------------------------------------------------------
  // EEPROM preload takes priority so a boot image wins over a racing write
  always_comb begin
    q2_sel_d = q2_sel_q;
    q3_sel_d = q3_sel_q;
    rdata_d  = 32'h0000_0000;
    ack_d    = reg_wr | reg_rd;
    if (eeprom_load && eeprom_addr == SQDR_OFS_QUAD2) begin
      q2_sel_d = eeprom_data[SQDR_SEL_LSB +: 2];
    end else if (reg_wr && reg_addr == SQDR_OFS_QUAD2) begin
      q2_sel_d = reg_wdata[SQDR_SEL_LSB +: 2];
    end
    if (eeprom_load && eeprom_addr == SQDR_OFS_QUAD3) begin
      q3_sel_d = eeprom_data[SQDR_SEL_LSB +: 2];
    end else if (reg_wr && reg_addr == SQDR_OFS_QUAD3) begin
      q3_sel_d = reg_wdata[SQDR_SEL_LSB +: 2];
    end
    // Reads return the lane chosen now, quads 0/1 and others read zero
    if (reg_rd) begin
      case (reg_addr)
        SQDR_OFS_QUAD2: begin
          rdata_d = pack_word(q2_exp_r[q2_sel_q], q2_act_r[q2_sel_q],
                              q2_cnt_r[q2_sel_q], q2_sel_q,
                              q2_prbs_en & ~q2_user_en);
        end
        SQDR_OFS_QUAD3: begin
          rdata_d = pack_word(q3_exp_r[q3_sel_q], q3_act_r[q3_sel_q],
                              q3_cnt_r[q3_sel_q], q3_sel_q,
                              q3_prbs_en & ~q3_user_en);
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q2_sel_q    <= SQDR_SEL_RST;
      q3_sel_q    <= SQDR_SEL_RST;
      reg_rdata_q <= 32'h0000_0000;
      reg_ack_q   <= 1'b0;
    end else begin
      q2_sel_q    <= q2_sel_d;
      q3_sel_q    <= q3_sel_d;
      reg_rdata_q <= rdata_d;
      reg_ack_q   <= ack_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_q2_sel_write;
    reg_wr && !eeprom_load && reg_addr == SQDR_OFS_QUAD2;
  endsequence

  a_sel_write_lands:
    assert property (@(posedge sys_clk) disable iff (!rstn)
    s_q2_sel_write
      |=> q2_sel_q == $past(reg_wdata[SQDR_SEL_LSB +: 2]))
    else $error("quad 2 select not written");

  // Reserved span sits between the select field and the source flag
  a_rsvd_read_zero:
    assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_ack_q |-> (reg_rdata_q[SQDR_SRC_BIT-1:SQDR_SEL_LSB+2] == 4'h0
      && !reg_rdata_q[SQDR_SRC_BIT+1]))
    else $error("reserved bits read nonzero");

  a_read_sel_lane:
    assert property (@(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr == SQDR_OFS_QUAD3)
      |=> reg_rdata_q[SQDR_CNT_LSB +: 8] == $past(q3_cnt_r[q3_sel_q]))
    else $error("read count not from selected lane");

  a_src_flag:
    assert property (@(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr == SQDR_OFS_QUAD2 && q2_user_en)
      |=> !reg_rdata_q[SQDR_SRC_BIT])
    else $error("source flag set in user pattern mode");

endmodule

// *** sqdr_top_test.sv ***
// Testbench: register access and lane result checks for quads 2 and 3
`timescale 1ns/1ps
module sqdr_top_test;
  import sqdr_pkg::*;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic        sys_clk, rstn;                  // Clock, active-low reset
  logic [11:0] reg_addr, eeprom_addr;          // Access offsets
  logic        reg_wr, reg_rd, eeprom_load;    // Strobes
  logic [31:0] reg_wdata, eeprom_data;         // Write data
  logic [31:0] reg_rdata_q;                    // Read data
  logic        reg_ack_q;                      // Access acknowledge
  logic        q2_user_en, q2_prbs_en;         // Quad 2 checker enables
  logic        q3_user_en, q3_prbs_en;         // Quad 3 checker enables
  logic [3:0]  q2_err, q3_err;                 // Lane error pulses
  logic [31:0] q2_exp, q2_act, q3_exp, q3_act; // Lane data bytes
  logic [1:0]  q2_sel_q, q3_sel_q;             // Lane select fields
  int          err_count, cmp_count, cycles;   // Bench counters
  logic [31:0] d;                              // Last read word
  // Mismatch bytes fed to quad 2; lanes 1 and 3 stay clean
  localparam logic [31:0] EXP_V = 32'h00A5_0011;
  localparam logic [31:0] ACT_V = 32'h005A_0022;
  sqdr_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .eeprom_load(eeprom_load), .eeprom_addr(eeprom_addr),
    .eeprom_data(eeprom_data), .q2_user_en(q2_user_en),
    .q2_prbs_en(q2_prbs_en), .q3_user_en(q3_user_en),
    .q3_prbs_en(q3_prbs_en), .q2_err(q2_err), .q2_exp(q2_exp),
    .q2_act(q2_act), .q3_err(q3_err), .q3_exp(q3_exp), .q3_act(q3_act),
    .q2_sel_q(q2_sel_q), .q3_sel_q(q3_sel_q));
  // ---------------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run needs under a thousand cycles; stop well past that
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Expected register word from its fields
  function automatic logic [31:0] word(logic s, logic [1:0] l,
      logic [7:0] c, logic [7:0] a, logic [7:0] e);
    return {1'b0, s, 4'h0, l, c, a, e};
  endfunction
  // Compare and count
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One write strobe, acknowledge checked one cycle later
  task automatic wr(logic [11:0] a, logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
    check("write ack", {31'h0, reg_ack_q}, 32'h1);
  endtask
  // One read strobe, data taken with the acknowledge
  task automatic rd(logic [11:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("read ack", {31'h0, reg_ack_q}, 32'h1);
    v = reg_rdata_q;
  endtask
  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, eeprom_load, q2_err, q3_err} = '0;
    {reg_addr, eeprom_addr, reg_wdata, eeprom_data} = '0;
    {q2_user_en, q2_prbs_en, q3_user_en, q3_prbs_en} = '0;
    {q2_exp, q2_act, q3_exp, q3_act} = '0;
    {err_count, cmp_count, cycles} = '0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset words, including quad 0, which is handled elsewhere
    rd(SQDR_OFS_QUAD2, d);
    check("q2 reset", d, 32'h0);
    rd(SQDR_OFS_QUAD3, d);
    check("q3 reset", d, 32'h0);
    rd(SQDR_OFS_QUAD0, d);
    check("q0 word", d, 32'h0);
    // All-ones write: only the select field may stick
    wr(SQDR_OFS_QUAD3, 32'hFFFF_FFFF);
    rd(SQDR_OFS_QUAD3, d);
    check("q3 rsvd", d, word(1'b0, 2'h3, 8'h00, 8'h00, 8'h00));
    check("q2 sel kept", {30'h0, q2_sel_q}, 32'h0);
    // User pattern errors on quad 2 lanes 0 and 2 in one cycle
    @(posedge sys_clk);
    q2_user_en <= 1'b1;
    @(posedge sys_clk);
    q2_err <= 4'h5;
    q2_exp <= EXP_V;
    q2_act <= ACT_V;
    @(posedge sys_clk);
    q2_err <= 4'h0;
    // Step the select through every lane code
    for (int i = 0; i < 4; i++) begin
      wr(SQDR_OFS_QUAD2, 32'(i) << SQDR_SEL_LSB);
      check("q2 sel", {30'h0, q2_sel_q}, 32'(i));
      rd(SQDR_OFS_QUAD2, d);
      check("q2 lane", d, word(1'b0, 2'(i), 8'(EXP_V[i*8+:8] != 8'h00),
        ACT_V[i*8+:8], EXP_V[i*8+:8]));
    end
    // PRBS errors on quad 3 lane 1, more than the counter holds
    @(posedge sys_clk);
    q3_prbs_en <= 1'b1;
    for (int n = 0; n < 260; n++) begin
      @(posedge sys_clk);
      q3_err <= 4'h2;
    end
    @(posedge sys_clk);
    q3_err <= 4'h0;
    wr(SQDR_OFS_QUAD3, 32'h0100_0000);
    rd(SQDR_OFS_QUAD3, d);
    check("q3 sat", d, word(1'b1, 2'h1, 8'hFF, 8'h00, 8'h00));
    // Disabling the checker clears the counter, data bytes remain
    @(posedge sys_clk);
    q3_prbs_en <= 1'b0;
    q2_user_en <= 1'b0;
    rd(SQDR_OFS_QUAD3, d);
    check("q3 clr", d, word(1'b0, 2'h1, 8'h00, 8'h00, 8'h00));
    rd(SQDR_OFS_QUAD2, d);
    check("q2 clr", d, word(1'b0, 2'h3, 8'h00, 8'h00, 8'h00));
    wr(SQDR_OFS_QUAD2, 32'h0200_0000);
    rd(SQDR_OFS_QUAD2, d);
    check("q2 held", d, word(1'b0, 2'h2, 8'h00, 8'h5A, 8'hA5));
    // Serial preload of the quad 3 select wins over a racing bus write
    @(posedge sys_clk);
    eeprom_load <= 1'b1;
    eeprom_addr <= SQDR_OFS_QUAD3;
    eeprom_data <= 32'h0200_0000;
    reg_wr      <= 1'b1;
    reg_addr    <= SQDR_OFS_QUAD3;
    reg_wdata   <= 32'h0300_0000;
    @(posedge sys_clk);
    eeprom_load <= 1'b0;
    reg_wr      <= 1'b0;
    #1;
    check("q3 preload", {30'h0, q3_sel_q}, 32'h2);
    // User pattern error on quad 3 lane 2, then its enable is dropped
    @(posedge sys_clk);
    q3_user_en <= 1'b1;
    @(posedge sys_clk);
    q3_err <= 4'h4;
    q3_exp <= 32'h0033_0000;
    q3_act <= 32'h00CC_0000;
    @(posedge sys_clk);
    q3_err <= 4'h0;
    rd(SQDR_OFS_QUAD3, d);
    check("q3 user", d, word(1'b0, 2'h2, 8'h01, 8'hCC, 8'h33));
    @(posedge sys_clk);
    q3_user_en <= 1'b0;
    rd(SQDR_OFS_QUAD3, d);
    check("q3 user clr", d, word(1'b0, 2'h2, 8'h00, 8'hCC, 8'h33));
    complete_run();
  end
endmodule
